// file: sim/eew_serial_write_ctrl_monitor.sv
// Purpose: Port-level assertions for the serial write-control block
// Assumes: Mode 0 link; SCK stands still outside frames
// Notes: SCK-side helpers restart on every CS_N rise
`timescale 1ns/1ps
`include "eew_params.svh"
module eew_serial_write_ctrl_monitor #(
  parameter int unsigned PROG_CYCLES = 20
) (
  // Core clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Serial link
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  input wire logic SO_OUT,
  input wire logic SO_OE,
  // Guard and observation
  input wire logic WP_N,
  input wire eew_pkg::eew_addr_t PEEK_ADDR,
  input wire eew_pkg::eew_byte_t PEEK_DATA
);
  import eew_pkg::*;
  logic [3:0] bit_cnt_reg;
  logic [7:0] op_reg;
  // Cleared by CS_N because SCK does not run between frames
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      bit_cnt_reg <= 4'h0;
      op_reg <= 8'h00;
    end else begin
      bit_cnt_reg <= (bit_cnt_reg == 4'hF) ? 4'h8 : bit_cnt_reg + 4'h1;
      if (!bit_cnt_reg[3]) begin
        op_reg <= {op_reg[6:0], SI};
      end
    end
  end
  sequence s_stat_rd;
    bit_cnt_reg[3] && op_reg == `EEW_OP_STAT_RD;
  endsequence
  opcode_quiet_a: assert property (@(posedge SCK) disable iff (SYS_RST)
    !bit_cnt_reg[3] |-> !SO_OE) else $error("SO driven during opcode");
  stat_drive_a: assert property (@(posedge SCK) disable iff (SYS_RST)
    s_stat_rd |-> SO_OE) else $error("status byte not driven");
  stat_hinib_a: assert property (@(posedge SCK) disable iff (SYS_RST)
    s_stat_rd ##0 !bit_cnt_reg[2] |-> !SO_OUT) else $error("status upper bits not zero");
  other_quiet_a: assert property (@(posedge SCK) disable iff (SYS_RST)
    bit_cnt_reg[3] && op_reg != `EEW_OP_STAT_RD |-> !SO_OE) else $error("SO driven outside status read");
  so_idle_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CS_N |-> !SO_OE) else $error("SO driven while deselected");
  so_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    SO_OE && !CS_N |=> SO_OE || CS_N) else $error("SO released inside frame");
  so_fall_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $changed(SO_OUT) |-> !SCK) else $error("SO changed outside SCK low");
  reset_quiet_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $fell(SYS_RST) |-> !SO_OE && PEEK_DATA == 8'h00) else $error("outputs not cleared by reset");
endmodule // eew_serial_write_ctrl_monitor

bind eew_serial_write_ctrl eew_serial_write_ctrl_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_eew_serial_write_ctrl_monitor (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CS_N(CS_N), .SCK(SCK), .SI(SI), .SO_OUT(SO_OUT),
  .SO_OE(SO_OE), .WP_N(WP_N), .PEEK_ADDR(PEEK_ADDR), .PEEK_DATA(PEEK_DATA));

// file: sim/eew_spi_master.sv
// Purpose: Mode 0 serial master driving the block's link pins
// Assumes: SCK period 30 ns, only inside frames
// Notes: Keeps the last eight bits sampled on SO; while SO is undriven it shifts in the inverse of the previous bit
`timescale 1ns/1ps
module eew_spi_master (
  // Link
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  logic [7:0] rx_reg = 8'h00;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic frame(input logic [55:0] tx, input int nbits);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = tx[55 - i];
      #15;
      sck = 1'b1;
      rx_reg = {rx_reg[6:0], so_oe ? so_out : ~rx_reg[0]};
      #15;
      sck = 1'b0;
    end
    #5;
    cs_n = 1'b1;
    si = ~si;
    #100; // Gap lets the core commit the frame
  endtask
endmodule // eew_spi_master

// file: sim/tb_eew_serial_write_ctrl.sv
// Purpose: Self-checking bench for the serial write-control block
// Assumes: Program cycle shortened to PROG core cycles
// Notes: Array cells are compared only after being written
`timescale 1ns/1ps
`include "eew_params.svh"
module tb_eew_serial_write_ctrl;
  import eew_pkg::*;
  localparam int PROG = 200;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wp_n = 1'b1;
  logic cs_n, sck, si, so_out, so_oe;
  eew_addr_t peek_addr = 9'h000;
  eew_addr_t a;
  eew_addr_t tst [6] = '{9'h1FF, 9'h180, 9'h17F, 9'h100, 9'h0FF, 9'h000};
  eew_byte_t peek_data, st;
  eew_byte_t mem_exp [512];
  logic [1:0] lvl_exp = 2'h0;
  logic [39:0] d;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  always #5 core_clk = ~core_clk;
  eew_serial_write_ctrl #(.PROG_CYCLES(PROG)) i_eew_serial_write_ctrl (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .CS_N(cs_n), .SCK(sck), .SI(si), .SO_OUT(so_out),
    .SO_OE(so_oe), .WP_N(wp_n), .PEEK_ADDR(peek_addr), .PEEK_DATA(peek_data));
  eew_spi_master i_eew_spi_master (.cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe));
  function automatic eew_byte_t stat_exp(input logic wel);
    return {4'h0, lvl_exp, wel, 1'b0};
  endfunction
  function automatic logic prot(input logic [1:0] lv, input eew_addr_t x);
    return (lv == 2'h1 && x >= 9'h180) || (lv == 2'h2 && x >= 9'h100) || lv == 2'h3;
  endfunction
  task automatic check(input string what, input eew_byte_t exp, input eew_byte_t got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input eew_byte_t op);
    i_eew_spi_master.frame({op, 48'h0}, 8);
  endtask
  task automatic rd_status();
    cmd(`EEW_OP_STAT_RD);
    i_eew_spi_master.frame({`EEW_OP_STAT_RD, 48'h0}, 16);
    st = i_eew_spi_master.rx_reg;
  endtask
  // Address bit 8 rides in opcode bit 3
  task automatic wr(input eew_addr_t x, input int n, input logic [39:0] data);
    i_eew_spi_master.frame({4'h0, x[8], `EEW_OP_WRITE_TAIL, x[7:0], data}, 16 + 8 * n);
  endtask
  task automatic settle(input logic busy, input logic wel);
    int n;
    n = 0;
    rd_status();
    check("busy", {7'h0, busy}, {7'h0, st[0]});
    while (st[0] !== 1'b0 && n < 10) begin
      rd_status();
      n++;
    end
    check("status", stat_exp(wel), st);
  endtask
  task automatic peek(input eew_addr_t x);
    @(posedge core_clk);
    #1;
    peek_addr = x;
    repeat (2) @(posedge core_clk);
    #1;
    check("array", mem_exp[x], peek_data);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h8F8DC36A));
    repeat (2) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    rd_status();
    check("reset status", 8'h00, st);
    cmd(`EEW_OP_SET_LATCH);
    rd_status();
    check("latch set", 8'h02, st);
    // Unknown opcode and a write cut inside its data byte must both be ignored
    i_eew_spi_master.frame({8'hC3, 48'h0}, 8);
    i_eew_spi_master.frame({4'h0, 1'b0, `EEW_OP_WRITE_TAIL, 8'hF0, 8'h5A, 32'h0}, 20);
    settle(1'b0, 1'b1);
    cmd(`EEW_OP_CLR_LATCH);
    rd_status();
    check("latch clear", 8'h00, st);
    foreach (tst[i]) begin
      cmd(`EEW_OP_SET_LATCH);
      mem_exp[tst[i]] = 8'($urandom);
      wr(tst[i], 1, {mem_exp[tst[i]], 32'h0});
      settle(1'b1, 1'b0);
    end
    a = 9'($urandom);
    a[1:0] = 2'h2;
    d = {$urandom, 8'($urandom)};
    cmd(`EEW_OP_SET_LATCH);
    wr(a, 5, d);
    wr(a, 1, ~d);
    settle(1'b1, 1'b0);
    for (int i = 0; i < 5; i++) mem_exp[{a[8:2], 2'(a[1:0] + i)}] = d[39 - 8 * i -: 8];
    for (int i = 0; i < 4; i++) peek({a[8:2], 2'(i)});
    wr(a, 1, {~mem_exp[a], 32'h0});
    settle(1'b0, 1'b0);
    peek(a);
    wp_n = 1'b0;
    cmd(`EEW_OP_SET_LATCH);
    wr(a, 1, {~mem_exp[a], 32'h0});
    i_eew_spi_master.frame({`EEW_OP_STAT_WR, 8'hFF, 40'h0}, 16);
    settle(1'b0, 1'b1);
    peek(a);
    cmd(`EEW_OP_CLR_LATCH);
    wp_n = 1'b1;
    for (int lv = 0; lv < 4; lv++) begin
      cmd(`EEW_OP_SET_LATCH);
      i_eew_spi_master.frame({`EEW_OP_STAT_WR, 4'($urandom), 2'(lv), 2'($urandom), 40'h0}, 16);
      lvl_exp = 2'(lv);
      settle(1'b1, 1'b0);
      foreach (tst[i]) begin
        cmd(`EEW_OP_SET_LATCH);
        d[39:32] = 8'($urandom);
        wr(tst[i], 1, d);
        settle(!prot(lvl_exp, tst[i]), prot(lvl_exp, tst[i]));
        if (!prot(lvl_exp, tst[i])) mem_exp[tst[i]] = d[39:32];
        cmd(`EEW_OP_CLR_LATCH);
        peek(tst[i]);
      end
    end
    conclude();
  end
endmodule // tb_eew_serial_write_ctrl

// file: verilog/eew_mem_if.sv
// Purpose: Carrier between the write controller and the array
// Assumes: Both ends run on the core clock
// Notes: Read data comes from a register in the array
`timescale 1ns/1ps
interface eew_mem_if;
  import eew_pkg::*;
  logic we;
  eew_addr_t waddr;
  eew_byte_t wdata;
  eew_addr_t raddr;
  eew_byte_t rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: verilog/eew_page_mem.sv
// Purpose: 512x8 array storage
// Assumes: One write and one read per core clock
// Notes: Read data is registered; cells power up unknown
`timescale 1ns/1ps
`include "eew_params.svh"
module eew_page_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Array port
  eew_mem_if.mem port
);
  import eew_pkg::*;

  eew_byte_t cell_reg [0:`EEW_ARRAY_BYTES-1];

  always_ff @(posedge clk) begin
    if (port.we) begin
      cell_reg[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port.rdata <= 8'h00;
    end else begin
      port.rdata <= cell_reg[port.raddr];
    end
  end

endmodule // eew_page_mem

// file: verilog/eew_params.svh
// Purpose: Constants for the serial EEPROM write-control block
// Assumes: Included by bare name from the array and write-control design files
// Notes: Timing counts derive from the core clock period
`ifndef EEW_PARAMS_SVH
`define EEW_PARAMS_SVH

// Opcodes
`define EEW_OP_SET_LATCH 8'h06
`define EEW_OP_CLR_LATCH 8'h04
`define EEW_OP_STAT_RD 8'h05
`define EEW_OP_STAT_WR 8'h01
`define EEW_OP_WRITE_TAIL 3'h2
`define EEW_OP_ADDR8_POS 3

// Status byte layout
`define EEW_ST_BUSY_POS 0
`define EEW_ST_WEL_POS 1
`define EEW_ST_BPLO_POS 2
`define EEW_ST_BPHI_POS 3
`define EEW_BP_RESET 2'h0

// Protected range lower bounds per level
`define EEW_PROT_L1_BASE 9'h180
`define EEW_PROT_L2_BASE 9'h100
`define EEW_PROT_L3_BASE 9'h000

// Array geometry
`define EEW_ARRAY_BYTES 512
`define EEW_PAGE_BYTES 4

// Self-timed program cycle
`define EEW_CLK_PERIOD_NS 10
`define EEW_PROG_TIME_NS 5000000
`define EEW_PROG_CYCLES ((`EEW_PROG_TIME_NS) / (`EEW_CLK_PERIOD_NS))

`endif

// file: verilog/eew_pkg.sv
// Purpose: Types shared by the write-control block and its array
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Program FSM states follow a Gray path except the status-write jump from IDLE to PROG
package eew_pkg;

  typedef logic [8:0] eew_addr_t;
  typedef logic [7:0] eew_byte_t;
  typedef logic [1:0] eew_col_t;

  typedef enum logic [1:0] {
    EEW_IDLE = 2'b00,
    EEW_COPY = 2'b01,
    EEW_PROG = 2'b11,
    EEW_DONE = 2'b10
  } eew_state_t;

endpackage

// file: verilog/eew_serial_write_ctrl.sv
// Purpose: Serial slave command decode, write latch, protection and timed programming
// Assumes: Mode 0/3 link; SCK stands still while CS_N is high
// Notes: Commands are committed in the core domain when CS_N rises
`timescale 1ns/1ps
`include "eew_params.svh"
// Function
// - Status byte is 0000, protect_level_hi, protect_level_lo, write latch, busy.
// - Write latch bit is read-only, 1 when write enabled.
// - Busy bit is read-only, 1 during an internal program cycle.
// - During programming only the busy bit of the status byte matters.
// - Status read ignores input after opcode and shifts status out MSB first.
// - Write latch is clear after reset; set_write_latch_cmd precedes every write.
// - clear_write_latch_cmd clears the latch and blocks all programming.
// - Array programs only with guard high, latch set, address unprotected.
// - Levels 00 none, 01 180-1FF, 10 100-1FF, 11 000-1FF protected.
// - Programming starts only when CS rises right after a data byte.
// - While programming, only status_read_cmd is accepted.
// - A write frame may carry up to four data bytes.
// - Only address bits 1..0 advance per byte; extra bytes wrap the page.
// - Write latch clears automatically when an array write completes.
// - Write with latch clear is discarded at CS rise.
// - status_write_cmd stores only data bits 3 and 2.
// - status_write_cmd needs guard high and latch set, else no change.
// - Opcodes 06 set latch, 04 clear latch, 05 status read.
// - Write opcode 0000A010 carries address bit 8 in opcode bit 3.
// - Input sampled on rising SCK from first edge, MSB first.
// - Status write starts at CS rise after its byte; latch clears at end.
module eew_serial_write_ctrl #(
  parameter int unsigned PROG_CYCLES = `EEW_PROG_CYCLES
) (
  // Core clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Serial link
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  output logic SO_OUT,
  output logic SO_OE,
  // Write guard pin
  input wire logic WP_N,
  // Array observation
  input wire eew_pkg::eew_addr_t PEEK_ADDR,
  output eew_pkg::eew_byte_t PEEK_DATA
);
  import eew_pkg::*;

  // Link domain: per-frame state, cleared asynchronously while deselected
  logic frame_clr;
  logic [2:0] bit_idx_reg;
  logic [1:0] byte_no_reg;
  logic [6:0] shift_reg;
  logic started_reg;
  logic stat_rd_active_reg;

  // Link domain: held results read by the core after CS_N rises, plus status sync and SO output registers
  eew_byte_t opcode_reg;
  eew_byte_t addr_lo_reg;
  eew_byte_t stat_data_reg;
  eew_byte_t page_reg [0:`EEW_PAGE_BYTES-1];
  logic [`EEW_PAGE_BYTES-1:0] page_mask_reg;
  eew_col_t col_reg;
  logic ready_reg;
  logic frame_tog_reg;
  logic [3:0] stat_s1_reg;
  logic [3:0] stat_s2_reg;
  eew_byte_t snap_reg;
  logic so_reg;
  logic so_oe_reg;

  // Link-domain decode
  eew_byte_t rx_byte;
  eew_byte_t op_now;
  logic byte_done;
  logic op_byte;
  logic arg_byte;
  logic data_byte;
  logic op_is_write;
  logic op_is_stat_wr;
  logic op_is_latch;
  logic first_edge;
  logic ready_next;

  // Core domain
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_prev_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic last_tog_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  logic wel_reg;
  logic [1:0] bp_reg;
  logic busy_reg;
  eew_state_t state_reg;
  eew_state_t state_next;
  logic [31:0] timer_reg;
  eew_col_t wcol_reg;
  eew_byte_t page_core_reg [0:`EEW_PAGE_BYTES-1];
  logic [`EEW_PAGE_BYTES-1:0] mask_core_reg;
  logic [6:0] base_core_reg;
  logic cs_rise;
  logic commit;
  logic c_set;
  logic c_clr;
  logic c_stat_wr;
  logic c_write;
  logic allowed;
  logic prot_hit;
  logic start_wr;
  logic start_sr;
  logic prog_last;
  eew_addr_t tgt_addr;
  eew_mem_if mem_bus ();
  eew_page_mem u_mem (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .port (mem_bus)
  );

  // Link side: CS_N high ends the frame; SCK is not relied on after the last bit
  assign frame_clr = CS_N | SYS_RST;
  assign rx_byte = {shift_reg, SI};
  assign byte_done = (bit_idx_reg == 3'h7);
  assign first_edge = ~started_reg;
  assign op_now = (byte_no_reg == 2'h0) ? rx_byte : opcode_reg;
  assign op_is_write = (op_now[7:4] == 4'h0) && (op_now[2:0] == `EEW_OP_WRITE_TAIL);
  assign op_is_stat_wr = (op_now == `EEW_OP_STAT_WR);
  assign op_is_latch = (op_now == `EEW_OP_SET_LATCH) || (op_now == `EEW_OP_CLR_LATCH);
  assign op_byte = byte_done && (byte_no_reg == 2'h0);
  assign arg_byte = byte_done && (byte_no_reg == 2'h1);
  assign data_byte = byte_done && (byte_no_reg == 2'h2) && op_is_write;
  // Only a frame that ends on a completed command byte may commit
  assign ready_next = (op_byte && op_is_latch) || (arg_byte && op_is_stat_wr) || data_byte;

  always_ff @(posedge SCK or posedge frame_clr) begin
    if (frame_clr) begin
      bit_idx_reg <= 3'h0;
      byte_no_reg <= 2'h0;
      shift_reg <= 7'h00;
      started_reg <= 1'b0;
      stat_rd_active_reg <= 1'b0;
    end else begin
      bit_idx_reg <= bit_idx_reg + 3'h1;
      shift_reg <= {shift_reg[5:0], SI};
      started_reg <= 1'b1;
      if (byte_done && (byte_no_reg != 2'h2)) begin
        byte_no_reg <= byte_no_reg + 2'h1;
      end
      if (op_byte && (rx_byte == `EEW_OP_STAT_RD)) begin
        stat_rd_active_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge SCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      opcode_reg <= 8'h00;
      addr_lo_reg <= 8'h00;
      stat_data_reg <= 8'h00;
      col_reg <= 2'h0;
      ready_reg <= 1'b0;
      frame_tog_reg <= 1'b0;
    end else begin
      ready_reg <= ready_next;
      if (first_edge) begin
        frame_tog_reg <= ~frame_tog_reg;
      end
      if (op_byte) begin
        opcode_reg <= rx_byte;
      end
      if (arg_byte && op_is_write) begin
        addr_lo_reg <= rx_byte;
        col_reg <= rx_byte[1:0];
      end
      if (arg_byte && op_is_stat_wr) begin
        stat_data_reg <= rx_byte;
      end
      if (data_byte) begin
        col_reg <= col_reg + 2'h1;
      end
    end
  end

  // Page buffer; a fifth byte lands on the first column again
  genvar gi;
  generate
    for (gi = 0; gi < `EEW_PAGE_BYTES; gi++) begin : g_page
      always_ff @(posedge SCK or posedge SYS_RST) begin
        if (SYS_RST) begin
          page_reg[gi] <= 8'h00;
          page_mask_reg[gi] <= 1'b0;
        end else if (first_edge) begin
          page_mask_reg[gi] <= 1'b0;
        end else if (data_byte && (col_reg == 2'(gi))) begin
          page_reg[gi] <= rx_byte;
          page_mask_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Status from the core crosses as a level; eight edges of opcode settle it
  always_ff @(posedge SCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stat_s1_reg <= 4'h0;
      stat_s2_reg <= 4'h0;
      snap_reg <= 8'h00;
    end else begin
      stat_s1_reg <= {bp_reg, wel_reg, busy_reg};
      stat_s2_reg <= stat_s1_reg;
      if (op_byte) begin
        snap_reg <= {4'h0, stat_s2_reg};
      end
    end
  end

  // Output shifts on falling SCK, MSB first, repeating while clocked
  always_ff @(negedge SCK or posedge frame_clr) begin
    if (frame_clr) begin
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      so_oe_reg <= stat_rd_active_reg;
      so_reg <= snap_reg[3'h7 - bit_idx_reg];
    end
  end

  assign SO_OUT = so_reg;
  assign SO_OE = so_oe_reg;

  // Core side
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      last_tog_reg <= 1'b0;
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= CS_N;
      cs_s2_reg <= cs_s1_reg;
      cs_prev_reg <= cs_s2_reg;
      tog_s1_reg <= frame_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      wp_s1_reg <= WP_N;
      wp_s2_reg <= wp_s1_reg;
      if (cs_rise) begin
        last_tog_reg <= tog_s2_reg;
      end
    end
  end

  // Link-side held values are stable while CS_N stays high
  assign cs_rise = cs_s2_reg & ~cs_prev_reg;
  assign commit = cs_rise && (tog_s2_reg != last_tog_reg) && ready_reg && (state_reg == EEW_IDLE);
  assign c_set = (opcode_reg == `EEW_OP_SET_LATCH);
  assign c_clr = (opcode_reg == `EEW_OP_CLR_LATCH);
  assign c_stat_wr = (opcode_reg == `EEW_OP_STAT_WR);
  assign c_write = (opcode_reg[7:4] == 4'h0) && (opcode_reg[2:0] == `EEW_OP_WRITE_TAIL);
  assign tgt_addr = {opcode_reg[`EEW_OP_ADDR8_POS], addr_lo_reg};
  assign allowed = wp_s2_reg && wel_reg;
  assign prot_hit = (bp_reg == 2'h1) ? (tgt_addr >= `EEW_PROT_L1_BASE) :
                    (bp_reg == 2'h2) ? (tgt_addr >= `EEW_PROT_L2_BASE) :
                    (bp_reg == 2'h3) ? (tgt_addr >= `EEW_PROT_L3_BASE) : 1'b0;
  assign start_wr = commit && c_write && allowed && ~prot_hit;
  assign start_sr = commit && c_stat_wr && allowed;
  assign prog_last = (timer_reg == PROG_CYCLES - 32'h1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EEW_IDLE: begin
        if (start_wr) begin
          state_next = EEW_COPY;
        end else if (start_sr) begin
          state_next = EEW_PROG;
        end
      end
      EEW_COPY: begin
        if (wcol_reg == 2'h3) begin
          state_next = EEW_PROG;
        end
      end
      EEW_PROG: begin
        if (prog_last) begin
          state_next = EEW_DONE;
        end
      end
      EEW_DONE: begin
        state_next = EEW_IDLE;
      end
      default: begin
        state_next = EEW_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_reg <= EEW_IDLE;
      busy_reg <= 1'b0;
      timer_reg <= 32'h0;
      wcol_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      busy_reg <= (state_next != EEW_IDLE);
      timer_reg <= (state_reg == EEW_PROG) ? timer_reg + 32'h1 : 32'h0;
      wcol_reg <= (state_reg == EEW_COPY) ? wcol_reg + 2'h1 : 2'h0;
    end
  end

  // Latch and protection level; commits never overlap a program cycle
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      wel_reg <= 1'b0;
      bp_reg <= `EEW_BP_RESET;
    end else begin
      if (commit && c_set) begin
        wel_reg <= 1'b1;
      end else if ((commit && c_clr) || (state_reg == EEW_DONE)) begin
        wel_reg <= 1'b0;
      end
      if (start_sr) begin
        bp_reg <= stat_data_reg[`EEW_ST_BPHI_POS:`EEW_ST_BPLO_POS];
      end
    end
  end

  // Snapshot the page so a later frame cannot disturb the copy
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mask_core_reg <= '0;
      base_core_reg <= 7'h00;
    end else if (start_wr) begin
      mask_core_reg <= page_mask_reg;
      base_core_reg <= tgt_addr[8:2];
    end
  end

  generate
    for (gi = 0; gi < `EEW_PAGE_BYTES; gi++) begin : g_core_page
      always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
          page_core_reg[gi] <= 8'h00;
        end else if (start_wr) begin
          page_core_reg[gi] <= page_reg[gi];
        end
      end
    end
  endgenerate

  // Only columns loaded in this frame are programmed
  assign mem_bus.we = (state_reg == EEW_COPY) && mask_core_reg[wcol_reg];
  assign mem_bus.waddr = {base_core_reg, wcol_reg};
  assign mem_bus.wdata = page_core_reg[wcol_reg];
  assign mem_bus.raddr = PEEK_ADDR;
  assign PEEK_DATA = mem_bus.rdata;

endmodule // eew_serial_write_ctrl
